// [rtl/mli_arb.sv]
// rotating or static priority pick among the sources of one level, winner given as a 4-bit index
`timescale 1ns/1ns
module mli_arb
  import mli_pkg::*;
(
  // requests of one level
  input  wire logic [NSRC-1:0] req,
  // rotation point and scheme
  input  wire logic [7:0]      rot,
  input  wire logic            rr_en,
  // winner
  output logic                 hit,
  output logic [3:0]           idx
);

  // scan from the lowest rank up so the best rank is written last
  always_comb begin
    logic [3:0] base;
    logic [3:0] j;
    base = rr_en ? rot[3:0] + 4'h1 : 4'h0;
    j    = 4'h0;
    hit  = 1'b0;
    idx  = 4'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      j = base + 4'(k);
      if (req[j]) begin
        hit = 1'b1;
        idx = j;
      end
    end
  end

endmodule : mli_arb

// [rtl/mli_ctrl.sv]
// three-level interrupt controller: apb registers, arbitration and executing flags
// Operation
// - low running flag held through pre-emption
// - rotating mode captures acknowledged low vector
// - rotation point vector ranks lowest
// - software reads and writes rotation point
// - rotation point kept when rotation off
// - rotation enable affects low level only
// - static order, smallest vector first
// - placement select picks boot or application
// - placement select writable only when unlocked
// - control bits 5:3 read zero
// - high enable gates high requests
// - medium enable gates medium requests
// - low enable gates low requests
// - cleared enable ignores from next cycle
// - nonmaskable running flag until return
// - high running flag until return
// - medium running flag until return
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module mli_ctrl
  import mli_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // peripheral requests
  input  wire logic [NSRC-1:0]      src_req,
  input  wire logic [NSRC-1:0][1:0] src_lvl,
  input  wire logic                 nmi_req,
  // core side
  output logic                      irq_valid,
  output mli_offer_s                irq_offer,
  input  wire logic                 irq_ack,
  input  wire logic                 return_from_handler,
  input  wire logic                 ccp_unlock,
  output logic                      vector_placement_select
);

  logic [7:0]      status_q;
  logic [7:0]      status_d;
  logic [7:0]      rot_q;
  logic [7:0]      ctrl_q;
  mli_ofs_e        ofs_q;
  mli_offer_s      offer_q;
  mli_offer_s      cand;
  logic            cand_ok;
  logic [2:0]      cur;
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] med_req;
  logic [NSRC-1:0] lo_req;
  logic            hi_hit;
  logic            med_hit;
  logic            lo_hit;
  logic [3:0]      hi_idx;
  logic [3:0]      med_idx;
  logic [3:0]      lo_idx;
  logic            taken;
  logic            acc_wr;
  logic            sel_st;
  logic            sel_rot;
  logic            sel_ctrl;
  logic [7:0]      rd_val;
  logic            bad;
  logic [31:0]     prdata_q;
  logic            pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // one word per register, misaligned or unmapped answers with slverr
  always_comb begin
    sel_st   = 1'b0;
    sel_rot  = 1'b0;
    sel_ctrl = 1'b0;
    bad      = 1'b0;
    rd_val   = 8'h00;
    if (paddr[1:0] != 2'h0) begin
      bad = 1'b1;
    end else if (paddr[11:2] == IDX_STATUS) begin
      sel_st = 1'b1;
      rd_val = status_q;
    end else if (paddr[11:2] == IDX_ROT) begin
      sel_rot = 1'b1;
      rd_val  = rot_q;
    end else if (paddr[11:2] == IDX_CTRL) begin
      sel_ctrl = 1'b1;
      rd_val   = ctrl_q;
    end else begin
      bad = 1'b1;
    end
  end

  // zero wait states: data is caught in setup so it comes from flops
  assign pready  = 1'b1;
  assign acc_wr  = psel && penable && pwrite;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // read data and error caught in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (pce) begin
      if (psel && !penable) begin
        prdata_q  <= {24'h00_0000, rd_val};
        pslverr_q <= bad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // placement select drives the vector base
  assign vector_placement_select = ctrl_q[BIT_VSEL];

  // control: reserved bits stay zero, placement guarded by the unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RST_CTRL;
    end else if (pce) begin
      if (acc_wr && sel_ctrl) begin
        ctrl_q <= pwdata[7:0] & CTRL_WMASK;
        if (!ccp_unlock) begin
          ctrl_q[BIT_VSEL] <= ctrl_q[BIT_VSEL];
        end
      end
    end
  end

  // rotation point: the hardware capture beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rot_q <= RST_ROT;
    end else if (pce) begin
      if (taken && !offer_q.nmi && offer_q.lvl == LVL_LO && ctrl_q[BIT_RR]) begin
        rot_q <= offer_q.vec;
      end else if (acc_wr && sel_rot) begin
        rot_q <= pwdata[7:0];
      end
      // no reinit when rotation is off
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request sorting and arbitration

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    assign hi_req[i]  = src_req[i] && (src_lvl[i] == LVL_HI);
    assign med_req[i] = src_req[i] && (src_lvl[i] == LVL_MED);
    assign lo_req[i]  = src_req[i] && (src_lvl[i] == LVL_LO);
  end

  // high and medium always static
  mli_arb u_hi (
    .req   (hi_req),
    .rot   (8'h00),
    .rr_en (1'b0),
    .hit   (hi_hit),
    .idx   (hi_idx)
  );

  mli_arb u_med (
    .req   (med_req),
    .rot   (8'h00),
    .rr_en (1'b0),
    .hit   (med_hit),
    .idx   (med_idx)
  );

  mli_arb u_lo (
    .req   (lo_req),
    .rot   (rot_q),
    .rr_en (ctrl_q[BIT_RR]),
    .hit   (lo_hit),
    .idx   (lo_idx)
  );

  // executing depth from the running flags
  always_comb begin
    if (status_q[BIT_NMI_RUN]) begin
      cur = CUR_NMI;
    end else if (status_q[BIT_HI_RUN]) begin
      cur = CUR_HI;
    end else if (status_q[BIT_MED_RUN]) begin
      cur = CUR_MED;
    end else if (status_q[BIT_LO_RUN]) begin
      cur = CUR_LO;
    end else begin
      cur = 3'h0;
    end
  end

  // pick the best enabled level above the executing one
  always_comb begin
    cand    = '0;
    cand_ok = 1'b0;
    if (nmi_req && !status_q[BIT_NMI_RUN]) begin
      cand_ok  = 1'b1;
      cand.nmi = 1'b1;
      cand.lvl = LVL_HI;
    end else if (hi_hit && ctrl_q[BIT_HI] && cur < CUR_HI) begin
      cand_ok  = 1'b1;
      cand.lvl = LVL_HI;
      cand.vec = {4'h0, hi_idx};
    end else if (med_hit && ctrl_q[BIT_MED] && cur < CUR_MED) begin
      cand_ok  = 1'b1;
      cand.lvl = LVL_MED;
      cand.vec = {4'h0, med_idx};
    end else if (lo_hit && ctrl_q[BIT_LO] && cur < CUR_LO) begin
      cand_ok  = 1'b1;
      cand.lvl = LVL_LO;
      cand.vec = {4'h0, lo_idx};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offer to the core

  assign irq_valid = (ofs_q == OFS_SHOW);
  assign irq_offer = offer_q;
  assign taken     = irq_ack && irq_valid;

  // offer refreshed each cycle so a higher arrival replaces a lower one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_q   <= OFS_IDLE;
      offer_q <= '0;
    end else if (pce) begin
      case (ofs_q)
        OFS_IDLE: begin
          if (cand_ok) begin
            ofs_q   <= OFS_SHOW;
            offer_q <= cand;
          end
        end
        OFS_SHOW: begin
          if (taken || !cand_ok) begin
            ofs_q <= OFS_IDLE;
          end else begin
            offer_q <= cand;
          end
        end
        default: begin
          ofs_q <= OFS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // executing flags

  // return clears the deepest flag, an ack in the same cycle still sets
  always_comb begin
    status_d = status_q;
    if (return_from_handler) begin
      if (status_q[BIT_NMI_RUN]) begin
        status_d[BIT_NMI_RUN] = 1'b0;
      end else if (status_q[BIT_HI_RUN]) begin
        status_d[BIT_HI_RUN] = 1'b0;
      end else if (status_q[BIT_MED_RUN]) begin
        status_d[BIT_MED_RUN] = 1'b0;
      end else begin
        status_d[BIT_LO_RUN] = 1'b0;
      end
    end
    if (taken) begin
      if (offer_q.nmi) begin
        status_d[BIT_NMI_RUN] = 1'b1;
      end else if (offer_q.lvl == LVL_HI) begin
        status_d[BIT_HI_RUN] = 1'b1;
      end else if (offer_q.lvl == LVL_MED) begin
        status_d[BIT_MED_RUN] = 1'b1;
      end else begin
        status_d[BIT_LO_RUN] = 1'b1;
      end
    end
  end

  // bus writes never reach the status flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= RST_STATUS;
    end else if (pce) begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !pce);

  sequence s_ack_lo;
    taken && !offer_q.nmi && offer_q.lvl == LVL_LO;
  endsequence

  sequence s_ret_nmi;
    return_from_handler && status_q[BIT_NMI_RUN] && !taken;
  endsequence

  AST_LO_SET: assert property (s_ack_lo |=> status_q[BIT_LO_RUN])
    else $error("low running flag not set after ack");

  AST_ROT_CAP: assert property (s_ack_lo ##0 ctrl_q[BIT_RR] |=> rot_q == $past(offer_q.vec))
    else $error("rotation point not captured");

  AST_STATIC: assert property (lo_hit && !ctrl_q[BIT_RR]
      |-> (lo_req & ((16'h0001 << lo_idx) - 16'h0001)) == 16'h0000)
    else $error("static low pick not smallest");

  AST_ROT_KEEP: assert property (!ctrl_q[BIT_RR] && !(acc_wr && sel_rot)
      |=> $stable(rot_q))
    else $error("rotation point changed while rotation off");

  AST_VSEL_LOCK: assert property (acc_wr && sel_ctrl && !ccp_unlock
      |=> $stable(ctrl_q[BIT_VSEL]))
    else $error("placement select written while locked");

  AST_RSV: assert property (ctrl_q[5:3] == 3'h0 && prdata[31:8] == 24'h00_0000)
    else $error("reserved bits not zero");

  AST_LO_OFF: assert property (acc_wr && sel_ctrl && !pwdata[BIT_LO]
      |=> !(cand_ok && !cand.nmi && cand.lvl == LVL_LO))
    else $error("low request passed after disable");

  AST_NMI_RET: assert property (s_ret_nmi |=> !status_q[BIT_NMI_RUN])
    else $error("nonmaskable flag not cleared on return");

  AST_ST_RO: assert property (acc_wr && sel_st && !taken && !return_from_handler
      |=> $stable(status_q))
    else $error("status changed by write");

  AST_ABOVE: assert property (cand_ok && !cand.nmi |-> {1'b0, cand.lvl} > cur)
    else $error("offer not above executing level");

endmodule : mli_ctrl

// [rtl/mli_pkg.sv]
// package: register map, field positions, codes and carriers of the interrupt controller
package mli_pkg;

  // number of requesting sources; source n requests vector n
  localparam int unsigned NSRC = 16;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS = 10'h000;
  localparam logic [9:0] IDX_ROT    = 10'h001;
  localparam logic [9:0] IDX_CTRL   = 10'h002;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_ROT    = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;

  // status field positions
  localparam int unsigned BIT_NMI_RUN = 7;
  localparam int unsigned BIT_HI_RUN  = 2;
  localparam int unsigned BIT_MED_RUN = 1;
  localparam int unsigned BIT_LO_RUN  = 0;

  // control field positions
  localparam int unsigned BIT_RR   = 7;
  localparam int unsigned BIT_VSEL = 6;
  localparam int unsigned BIT_HI   = 2;
  localparam int unsigned BIT_MED  = 1;
  localparam int unsigned BIT_LO   = 0;

  // writable control bits; bits 5:3 always read zero
  localparam logic [7:0] CTRL_WMASK = 8'hc7;

  // level codes presented with each request
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_LO  = 2'h1;
  localparam logic [1:0] LVL_MED = 2'h2;
  localparam logic [1:0] LVL_HI  = 2'h3;

  // executing depth, 0 = thread level
  localparam logic [2:0] CUR_LO  = 3'h1;
  localparam logic [2:0] CUR_MED = 3'h2;
  localparam logic [2:0] CUR_HI  = 3'h3;
  localparam logic [2:0] CUR_NMI = 3'h4;

  // request offered to the core
  typedef struct packed {
    logic       nmi;
    logic [1:0] lvl;
    logic [7:0] vec;
  } mli_offer_s;

  // offer state, gray along idle -> show
  typedef enum logic [1:0] {
    OFS_IDLE = 2'h0,
    OFS_SHOW = 2'h1
  } mli_ofs_e;

endpackage : mli_pkg

// [verification/mli_core_model.sv]
// core model: takes offers after a set delay and pulses handler returns
`timescale 1ns/1ns
module mli_core_model
  import mli_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // offer from the controller
  input  wire logic       irq_valid,
  input  wire mli_offer_s irq_offer,
  // bench control
  input  wire logic       go,
  input  wire logic [3:0] dly,
  input  wire logic       ret,
  // core side outputs
  output logic            irq_ack,
  output logic            return_from_handler,
  output mli_offer_s      got,
  output logic [7:0]      n_taken
);
  logic [3:0] wait_q;

  //////////////////////////////////////////////////////////////////////////////
  // ack only after dly shown cycles, so prompt and slow cores both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      wait_q  <= 4'h0;
      got     <= '0;
      n_taken <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (irq_ack && irq_valid) begin
        got     <= irq_offer;
        n_taken <= n_taken + 8'h01;
      end
      if (!irq_valid || irq_ack) wait_q <= 4'h0;
      else if (wait_q != dly) wait_q <= wait_q + 4'h1;
      else if (go) irq_ack <= 1'b1;
    end
  end

  // return is one pulse per bench request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) return_from_handler <= 1'b0;
    else return_from_handler <= ret;
  end
endmodule : mli_core_model

// [verification/mli_ctrl_tb.sv]
// testbench for the interrupt controller: register access and offer sequences
`timescale 1ns/1ns
module mli_ctrl_tb
  import mli_pkg::*;
;
  logic                 pclk, presetn, pce, psel, penable, pwrite, nmi_req, ccp, go, ret;
  logic                 pready, pslverr, irq_valid, irq_ack, rfh, vsel, err;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [NSRC-1:0]      src_req;
  logic [NSRC-1:0][1:0] src_lvl;
  logic [3:0]           dly;
  logic [7:0]           n_taken, n0, v;
  logic [7:0]           st [4];
  logic [1:0]           lv;
  mli_offer_s           irq_offer, got;
  int                   miscompares, compares, cyc, k;

  mli_ctrl i_mli_ctrl (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .src_lvl(src_lvl),
    .nmi_req(nmi_req), .irq_valid(irq_valid), .irq_offer(irq_offer), .irq_ack(irq_ack),
    .return_from_handler(rfh), .ccp_unlock(ccp), .vector_placement_select(vsel));
  mli_core_model i_mli_core_model (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
    .irq_offer(irq_offer), .go(go), .dly(dly), .ret(ret), .irq_ack(irq_ack),
    .return_from_handler(rfh), .got(got), .n_taken(n_taken));

  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp8

  task automatic cmpo(input mli_offer_s g, input mli_offer_s e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmpo

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    cmp8(rd[7:0], e);
  endtask : rdc

  task automatic srcs(input logic [NSRC-1:0] m, input logic [1:0] l);
    @(posedge pclk);
    src_req <= m;
    for (k = 0; k < NSRC; k++) src_lvl[k] <= m[k] ? l : LVL_OFF;
  endtask : srcs

  // let the core take one offer, bounded wait
  task automatic take(input mli_offer_s e);
    n0 = n_taken;
    @(posedge pclk);
    go <= 1'b1;
    for (k = 0; k < 64 && n_taken === n0; k++) @(negedge pclk);
    @(posedge pclk);
    go <= 1'b0;
    // a missed ack must not pass on a stale capture
    cmp8(n_taken - n0, 8'h01);
    cmpo(got, e);
  endtask : take

  task automatic rtn();
    @(posedge pclk);
    ret <= 1'b1;
    @(posedge pclk);
    ret <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : rtn

  task automatic quiet();
    repeat (4) @(negedge pclk);
    cmp8({7'h00, irq_valid}, 8'h00);
  endtask : quiet

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, nmi_req, ccp, go, ret} = '0;
    {paddr, pwdata, src_req, src_lvl, miscompares, compares, cyc} = '0;
    dly = 4'h2;
    pce = 1'b1;
    st  = '{8'h01, 8'h03, 8'h07, 8'h87};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 3; a++) rdc(12'(4 * a), 8'h00);
    apb(1'b0, 12'h00c, 8'h00);
    cmp8({7'h00, err}, 8'h01);
    apb(1'b0, 12'h005, 8'h00);
    cmp8({7'h00, err}, 8'h01);
    // frozen by the clock enable, the rotation write is dropped
    @(posedge pclk) pce <= 1'b0;
    apb(1'b1, 12'h004, 8'h5a);
    pce <= 1'b1;
    rdc(12'h004, 8'h00);
    apb(1'b1, 12'h008, 8'hff);
    rdc(12'h008, 8'h87);
    @(posedge pclk) ccp <= 1'b1;
    apb(1'b1, 12'h008, 8'h40);
    rdc(12'h008, 8'h40);
    cmp8({7'h00, vsel}, 8'h01);
    apb(1'b1, 12'h000, 8'hff);
    rdc(12'h000, 8'h00);
    apb(1'b1, 12'h004, 8'ha5);
    rdc(12'h004, 8'ha5);
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h008, 8'h00);
    for (int s = 1; s < 4; s++) begin
      srcs(16'h0001, 2'(s));
      quiet();
    end
    apb(1'b1, 12'h008, 8'h01);
    srcs(16'h0028, LVL_LO);
    take('{1'b0, LVL_LO, 8'h03});
    rdc(12'h000, 8'h01);
    rtn();
    rdc(12'h000, 8'h00);
    apb(1'b1, 12'h008, 8'h00);
    quiet();
    dly <= 4'h0;
    apb(1'b1, 12'h008, 8'h81);
    take('{1'b0, LVL_LO, 8'h03});
    rdc(12'h004, 8'h03);
    rtn();
    take('{1'b0, LVL_LO, 8'h05});
    rtn();
    apb(1'b1, 12'h004, 8'h04);
    take('{1'b0, LVL_LO, 8'h05});
    rtn();
    // rotation point kept, static order back
    apb(1'b1, 12'h008, 8'h01);
    rdc(12'h004, 8'h05);
    take('{1'b0, LVL_LO, 8'h03});
    rtn();
    dly <= 4'h3;
    apb(1'b1, 12'h008, 8'h07);
    for (int s = 0; s < 4; s++) begin
      lv = (s < 3) ? 2'(s + 1) : LVL_HI;
      v  = (s < 3) ? 8'(s + 3) : 8'h00;
      srcs((s < 3) ? 16'h0001 << (s + 3) : 16'h0000, lv);
      nmi_req <= (s == 3);
      take('{s == 3, lv, v});
      rdc(12'h000, st[s]);
      if (s == 0) begin
        srcs(16'h0020, LVL_LO);
        quiet();
      end
    end
    nmi_req <= 1'b0;
    for (int s = 3; s >= 0; s--) begin
      rtn();
      rdc(12'h000, (s > 0) ? st[s - 1] : 8'h00);
    end
    complete_run();
  end
endmodule : mli_ctrl_tb
